// ---- hw/servo_input_command_logic.sv ----
// Servo input terminal interpreter: homing, pulse gate, speed select, probes
// Functional notes
// R1: Homing runs only in position control mode
// R2: Optional homing presets offset at limit on
// R3: Low-speed homing moves, limit rise sets home
// R4: Mode variant picks forward or reverse travel
// R5: Fast homing one: limit rise sets home
// R6: Fast homing two: first index after limit
// R7: Request withdrawn: stop, homing stays incomplete
// R8: Successful homing asserts positioning complete
// R9: Without homing, power-up position is zero
// R10: Homing loads offset even with absolute encoder
// R11: Controller keeps first homing travel within 30 minutes
// R12: Pulses counted only when gate, mode, source
// R13: Error clear rising edge copies actual position
// R14: Direction inputs sign selected multistage speed
// R15: Gain change selects second gains, position only
// R16: Gear select input picks second gear ratio
// R17: Multi-turn clear after 4 s held on
// R18: Controller holds encoder clear, then alarm reset
// R19: External fault raises code 12, error state
// R20: Controller drops fault input before alarm reset
// R21: Probe edges capture position when program runs
// R22: Polarity bit per terminal inverts active level
// R23: Positioning complete drops at homing start
// R24: Terminals sampled, edges from successive samples
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "servo_input_consts.svh"
module servo_input_command_logic #(
  parameter int MT_HOLD_CYC = `MT_HOLD_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] term_in,
  input  wire logic        encoder_index,
  input  wire logic        pos_mode,
  input  wire logic        in_position,
  input  wire logic        cmd_pulse,
  input  wire logic        cmd_dir,
  input  wire logic [31:0] actual_position,
  input  wire logic        prog_running,
  output logic             positioning_complete,
  output logic             homing_move,
  output logic             homing_reverse,
  output logic             homing_fast,
  output logic             pos_preset,
  output logic      [31:0] pos_preset_val,
  output logic      [31:0] cmd_position,
  output logic      [15:0] speed_cmd,
  output logic             gain_set2,
  output logic             gear_set2,
  output logic             enc_mt_clear,
  output logic      [7:0]  error_code,
  output logic             dyn_brake
);
  logic [4:0]  ctrl_r;              // Homing mode, braking select, source
  logic [16:0] pol_r;               // Open-active polarity per terminal
  logic [15:0] off_hi_r;            // Home offset high half
  logic [15:0] off_lo_r;            // Home offset low half
  logic [15:0] spd_r [3];           // Signed multistage speeds
  logic [31:0] prb_a_r;             // Probe A captured position
  logic [31:0] prb_b_r;             // Probe B captured position
  logic        ack_r;               // Bus acknowledge
  logic [31:0] rdat_r;              // Bus read data
  logic [16:0] lvl;                 // Active levels
  logic [16:0] rise;                // Off-to-on edges
  logic [16:0] fall;                // On-to-off edges
  servo_input_pkg::home_state_t hst_r;  // Homing state
  logic        homed_r;             // Homing finished since power-up
  logic        pcomp_r;             // Positioning complete
  logic        preset_r;            // Position preset strobe
  logic [31:0] preset_val_r;        // Value loaded with the strobe
  logic [31:0] cmd_pos_r;           // Position command
  logic [15:0] speed_r;             // Speed command
  logic        fault_r;             // Error state latched
  logic [31:0] mtc_cnt_r;           // Hold time of encoder clear
  logic        mtc_r;               // Multi-turn clear strobe
  logic        bus_req;             // New bus cycle this edge
  logic        wr;                  // Write accepted this edge
  logic        home_ok;             // Homing may run
  logic        busy;                // Homing sequence in flight
  logic [2:0]  hmode;               // Homing mode setting
  logic        src_prog;            // Program position source
  logic [31:0] offset;              // Full home offset

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign hmode    = ctrl_r[`CTRL_HMODE_LSB +: 3];
  assign src_prog = ctrl_r[`CTRL_SRC_BIT];
  assign offset   = {off_hi_r, off_lo_r};
  assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & ce;  // Lands on the edge the master sees ack

  // R22 polarity per terminal
  term_edge #(.W(`N_TERM)) u_edge (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .raw  ({encoder_index, term_in} ^ pol_r),
    .lvl  (lvl),
    .rise (rise),
    .fall (fall)
  );

  // Acknowledge one cycle after the request; dropped the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else if (ce) begin
      ack_r <= bus_req;
    end
  end

  // Configuration registers written by software
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r   <= `CTRL_RST;
      pol_r    <= `POL_RST;
      off_hi_r <= `HALF_RST;
      off_lo_r <= `HALF_RST;
      spd_r[0] <= `HALF_RST;
      spd_r[1] <= `HALF_RST;
      spd_r[2] <= `HALF_RST;
    end else if (wr) begin
      unique case (wb_adr_i)
        `REG_CTRL: begin
          if (wb_sel_i[0]) begin
            ctrl_r <= wb_dat_i[4:0];
          end
        end
        `REG_POLARITY: begin
          pol_r <= {wb_sel_i[2] ? wb_dat_i[16] : pol_r[16], merge16(pol_r[15:0], wb_dat_i, wb_sel_i)};
        end
        `REG_HOME_OFF_HI: off_hi_r <= merge16(off_hi_r, wb_dat_i, wb_sel_i);
        `REG_HOME_OFF_LO: off_lo_r <= merge16(off_lo_r, wb_dat_i, wb_sel_i);
        `REG_SPEED1:      spd_r[0] <= merge16(spd_r[0], wb_dat_i, wb_sel_i);
        `REG_SPEED2:      spd_r[1] <= merge16(spd_r[1], wb_dat_i, wb_sel_i);
        `REG_SPEED3:      spd_r[2] <= merge16(spd_r[2], wb_dat_i, wb_sel_i);
        // Read-only and unmapped words ignore writes
        default: ;
      endcase
    end
  end

  // Read mux, registered so data lines up with the acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      rdat_r <= '0;
    end else if (ce && bus_req) begin
      unique case (wb_adr_i)
        `REG_CTRL:        rdat_r <= {27'h0, ctrl_r};
        `REG_POLARITY:    rdat_r <= {15'h0, pol_r};
        `REG_HOME_OFF_HI: rdat_r <= {16'h0, off_hi_r};
        `REG_HOME_OFF_LO: rdat_r <= {16'h0, off_lo_r};
        `REG_SPEED1:      rdat_r <= {16'h0, spd_r[0]};
        `REG_SPEED2:      rdat_r <= {16'h0, spd_r[1]};
        `REG_SPEED3:      rdat_r <= {16'h0, spd_r[2]};
        `REG_STATUS:      rdat_r <= {26'h0, gear_set2, gain_set2, fault_r, pcomp_r, busy, homed_r};
        `REG_PROBE_A_HI:  rdat_r <= {16'h0, prb_a_r[31:16]};
        `REG_PROBE_A_LO:  rdat_r <= {16'h0, prb_a_r[15:0]};
        `REG_PROBE_B_HI:  rdat_r <= {16'h0, prb_b_r[31:16]};
        `REG_PROBE_B_LO:  rdat_r <= {16'h0, prb_b_r[15:0]};
        `REG_CMD_POS:     rdat_r <= cmd_pos_r;
        // Unmapped words read as zero
        default:          rdat_r <= '0;
      endcase
    end
  end

  // R1 homing needs position mode and servo on
  assign home_ok = pos_mode & lvl[`T_SERVO_ON];
  assign busy    = (hst_r == servo_input_pkg::H_RUN) || (hst_r == servo_input_pkg::H_WAIT_INDEX);

  // Homing sequencer; a lost request or mode aborts without marking home
  always_ff @(posedge clk) begin
    if (rst) begin
      hst_r <= servo_input_pkg::H_IDLE;
    end else if (ce) begin
      unique case (hst_r)
        servo_input_pkg::H_IDLE: begin
          // R1 start only in position mode
          if (home_ok && rise[`T_HOME_REQ]) begin
            hst_r <= servo_input_pkg::H_RUN;
          end
        end
        servo_input_pkg::H_RUN: begin
          // R7 withdrawn request stops homing
          if (!home_ok || !lvl[`T_HOME_REQ]) begin
            hst_r <= servo_input_pkg::H_IDLE;
          end else if (rise[`T_HOME_LIMIT]) begin
            // R6 index modes wait for phase Z
            if (hmode == `HM_FAST_IX_F || hmode == `HM_FAST_IX_R) begin
              hst_r <= servo_input_pkg::H_WAIT_INDEX;
            end else begin
              hst_r <= servo_input_pkg::H_DONE;
            end
          end
        end
        servo_input_pkg::H_WAIT_INDEX: begin
          if (!home_ok || !lvl[`T_HOME_REQ]) begin
            hst_r <= servo_input_pkg::H_IDLE;
          end else if (rise[`T_INDEX]) begin
            hst_r <= servo_input_pkg::H_DONE;
          end
        end
        servo_input_pkg::H_DONE: begin
          // Held until the request is released
          if (!home_ok || !lvl[`T_HOME_REQ]) begin
            hst_r <= servo_input_pkg::H_IDLE;
          end
        end
      endcase
    end
  end

  // R2 R3 R5 R6 R10 offset preset at the home event
  always_ff @(posedge clk) begin
    if (rst) begin
      preset_r     <= 1'b0;
      preset_val_r <= '0;
      homed_r      <= 1'b0;
    end else if (ce) begin
      preset_r <= 1'b0;
      if (home_ok && lvl[`T_HOME_REQ] &&
          ((hst_r == servo_input_pkg::H_RUN && rise[`T_HOME_LIMIT] &&
            hmode != `HM_FAST_IX_F && hmode != `HM_FAST_IX_R) ||
           (hst_r == servo_input_pkg::H_WAIT_INDEX && rise[`T_INDEX]))) begin
        preset_r     <= 1'b1;
        preset_val_r <= offset;
        homed_r      <= 1'b1;
      end
    end
  end

  // R4 R3 R5 travel direction and speed class; optional mode does not move
  assign homing_move    = busy && hst_r == servo_input_pkg::H_RUN && hmode != `HM_OPTIONAL ||
                          hst_r == servo_input_pkg::H_WAIT_INDEX;
  assign homing_reverse = (hmode == `HM_SLOW_R) || (hmode == `HM_FAST_A_R) || (hmode == `HM_FAST_IX_R);
  assign homing_fast    = (hmode >= `HM_FAST_A_F);

  // R8 R23 complete held while homed and requested, low during homing
  always_ff @(posedge clk) begin
    if (rst) begin
      pcomp_r <= 1'b0;
    end else if (ce) begin
      pcomp_r <= home_ok && ((hst_r == servo_input_pkg::H_DONE) ||
                             (hst_r == servo_input_pkg::H_IDLE && in_position));
    end
  end

  // R12 R13 position command; the clear edge wins over a pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_pos_r <= '0;
    end else if (ce) begin
      if (pos_mode && rise[`T_ERR_CLEAR]) begin
        cmd_pos_r <= actual_position;
      end else if (pos_mode && !src_prog && lvl[`T_PULSE_EN] && cmd_pulse) begin
        cmd_pos_r <= cmd_dir ? cmd_pos_r - 32'h1 : cmd_pos_r + 32'h1;
      end
    end
  end

  // R14 signed multistage speed; both or neither direction gives zero
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_r <= '0;
    end else if (ce) begin
      if (!lvl[`T_SERVO_ON] || (lvl[`T_FORWARD] == lvl[`T_REVERSE]) ||
          lvl[`T_SPEED_SEL2:`T_SPEED_SEL1] == 2'h0) begin
        speed_r <= '0;
      end else if (lvl[`T_REVERSE]) begin
        speed_r <= 16'h0 - spd_r[lvl[`T_SPEED_SEL2:`T_SPEED_SEL1] - 2'h1];
      end else begin
        speed_r <= spd_r[lvl[`T_SPEED_SEL2:`T_SPEED_SEL1] - 2'h1];
      end
    end
  end

  // R17 multi-turn clear fires once after the hold time
  always_ff @(posedge clk) begin
    if (rst) begin
      mtc_cnt_r <= '0;
      mtc_r     <= 1'b0;
    end else if (ce) begin
      mtc_r <= 1'b0;
      if (!lvl[`T_ENC_CLEAR]) begin
        mtc_cnt_r <= '0;
      end else if (mtc_cnt_r < MT_HOLD_CYC) begin
        mtc_cnt_r <= mtc_cnt_r + 32'h1;
        mtc_r     <= (mtc_cnt_r == MT_HOLD_CYC - 1);
      end
    end
  end

  // R19 fault latch; alarm reset clears only with the input released
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_r <= 1'b0;
    end else if (ce) begin
      if (lvl[`T_EXT_FAULT]) begin
        fault_r <= 1'b1;
      end else if (rise[`T_ALARM_RESET]) begin
        fault_r <= 1'b0;
      end
    end
  end

  // R21 probe captures on either edge while the program runs
  always_ff @(posedge clk) begin
    if (rst) begin
      prb_a_r <= '0;
      prb_b_r <= '0;
    end else if (ce && src_prog && prog_running) begin
      if (rise[`T_PROBE_A] || fall[`T_PROBE_A]) begin
        prb_a_r <= actual_position;
      end
      if (rise[`T_PROBE_B] || fall[`T_PROBE_B]) begin
        prb_b_r <= actual_position;
      end
    end
  end

  // R15 R16 gain and gear selection
  assign gain_set2 = lvl[`T_GAIN_CHANGE] & pos_mode;
  assign gear_set2 = lvl[`T_GEAR_SEL];

  // Output drive
  assign wb_ack_o             = ack_r;
  assign wb_dat_o             = rdat_r;
  assign positioning_complete = pcomp_r;
  assign pos_preset           = preset_r;
  // R9 value is zero until a homing completes
  assign pos_preset_val       = preset_val_r;
  assign cmd_position         = cmd_pos_r;
  assign speed_cmd            = speed_r;
  assign enc_mt_clear         = mtc_r;
  assign error_code           = fault_r ? `ERR_EXT_FAULT : `ERR_NONE;
  assign dyn_brake            = fault_r & ctrl_r[`CTRL_BRAKE_BIT];

  // Named steps of the homing sequence
  sequence s_in_run;
    ce && hst_r == servo_input_pkg::H_RUN && home_ok && lvl[`T_HOME_REQ];
  endsequence
  sequence s_in_wait;
    ce && hst_r == servo_input_pkg::H_WAIT_INDEX && home_ok && lvl[`T_HOME_REQ];
  endsequence

  property p_mode_gate;
    @(posedge clk) disable iff (rst) (ce && hst_r == servo_input_pkg::H_IDLE && !pos_mode) |=> hst_r == servo_input_pkg::H_IDLE;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("homing left idle outside position mode"); // R1

  property p_preset_val;
    @(posedge clk) disable iff (rst) $rose(homed_r) |-> pos_preset && pos_preset_val == $past(offset);
  endproperty
  a_preset_val: assert property (p_preset_val) else $error("home preset without offset value"); // R10

  property p_index_home;
    @(posedge clk) disable iff (rst) (s_in_wait ##0 rise[`T_INDEX])
      |=> pos_preset && hst_r == servo_input_pkg::H_DONE;
  endproperty
  a_index_home: assert property (p_index_home) else $error("index pulse did not set home"); // R6

  property p_abort;
    @(posedge clk) disable iff (rst) (ce && busy && !lvl[`T_HOME_REQ]) |=> hst_r == servo_input_pkg::H_IDLE && !homing_move && !pos_preset;
  endproperty
  a_abort: assert property (p_abort) else $error("withdrawn request did not stop homing"); // R7

  property p_limit_home;
    @(posedge clk) disable iff (rst)
      (s_in_run ##0 rise[`T_HOME_LIMIT] && hmode != `HM_FAST_IX_F && hmode != `HM_FAST_IX_R)
      |=> pos_preset && hst_r == servo_input_pkg::H_DONE;
  endproperty
  a_limit_home: assert property (p_limit_home) else $error("home limit edge did not set home"); // R3

  property p_complete;
    @(posedge clk) disable iff (rst) (ce && hst_r == servo_input_pkg::H_DONE && home_ok) |=> positioning_complete;
  endproperty
  a_complete: assert property (p_complete) else $error("homing done without positioning complete"); // R8

  property p_start_drop;
    @(posedge clk) disable iff (rst) (s_in_run ##1 ce) |-> !positioning_complete;
  endproperty
  a_start_drop: assert property (p_start_drop) else $error("positioning complete high during homing"); // R23

  property p_err_clear;
    @(posedge clk) disable iff (rst) (ce && pos_mode && rise[`T_ERR_CLEAR]) |=> cmd_position == $past(actual_position);
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error clear edge did not copy position"); // R13

  property p_zero_speed;
    @(posedge clk) disable iff (rst) (ce && lvl[`T_FORWARD] == lvl[`T_REVERSE]) |=> speed_cmd == 16'h0;
  endproperty
  a_zero_speed: assert property (p_zero_speed) else $error("speed not zero with equal directions"); // R14

  property p_mt_once;
    @(posedge clk) disable iff (rst) enc_mt_clear |-> mtc_cnt_r == MT_HOLD_CYC && $past(lvl[`T_ENC_CLEAR]);
  endproperty
  a_mt_once: assert property (p_mt_once) else $error("multi-turn clear before hold time"); // R17

  property p_fault;
    @(posedge clk) disable iff (rst) (ce && lvl[`T_EXT_FAULT]) |=> error_code == `ERR_EXT_FAULT;
  endproperty
  a_fault: assert property (p_fault) else $error("external fault did not raise error"); // R19
endmodule
`default_nettype wire

// ---- hw/servo_input_consts.svh ----
// Constants for the servo input command logic: offsets, fields, terminals, timing
`ifndef SERVO_INPUT_CONSTS_SVH
`define SERVO_INPUT_CONSTS_SVH

// Clock rate and hold time of the multi-turn clear input
`define CLK_KHZ         125000
`define MT_HOLD_MS      4000
`define MT_HOLD_CYC     (`MT_HOLD_MS * `CLK_KHZ)

// Input terminal positions (polarity bit index equals terminal index)
`define N_TERM          17
`define T_SERVO_ON      0
`define T_ALARM_RESET   1
`define T_HOME_REQ      2
`define T_HOME_LIMIT    3
`define T_PULSE_EN      4
`define T_ERR_CLEAR     5
`define T_FORWARD       6
`define T_REVERSE       7
`define T_SPEED_SEL1    8
`define T_SPEED_SEL2    9
`define T_GAIN_CHANGE   10
`define T_GEAR_SEL      11
`define T_ENC_CLEAR     12
`define T_EXT_FAULT     13
`define T_PROBE_A       14
`define T_PROBE_B       15
`define T_INDEX         16

// Homing mode setting codes
`define HM_OPTIONAL     3'h0
`define HM_SLOW_F       3'h1
`define HM_SLOW_R       3'h2
`define HM_FAST_A_F     3'h3
`define HM_FAST_A_R     3'h4
`define HM_FAST_IX_F    3'h5
`define HM_FAST_IX_R    3'h6

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_POLARITY    8'h04
`define REG_HOME_OFF_HI 8'h08
`define REG_HOME_OFF_LO 8'h0c
`define REG_SPEED1      8'h10
`define REG_SPEED2      8'h14
`define REG_SPEED3      8'h18
`define REG_STATUS      8'h1c
`define REG_PROBE_A_HI  8'h20
`define REG_PROBE_A_LO  8'h24
`define REG_PROBE_B_HI  8'h28
`define REG_PROBE_B_LO  8'h2c
`define REG_CMD_POS     8'h30

// Control register fields
`define CTRL_HMODE_LSB  0
`define CTRL_BRAKE_BIT  3
`define CTRL_SRC_BIT    4

// Reset values
`define CTRL_RST        5'h00
`define POL_RST         17'h00000
`define HALF_RST        16'h0000

// Error code raised by the external fault input
`define ERR_NONE        8'h00
`define ERR_EXT_FAULT   8'h0c

`endif

// ---- hw/servo_input_pkg.sv ----
// Types shared by the servo input command logic
package servo_input_pkg;
  // Homing sequencer states
  typedef enum logic [1:0] {
    H_IDLE,
    H_RUN,
    H_WAIT_INDEX,
    H_DONE
  } home_state_t;
endpackage

// ---- hw/term_edge.sv ----
// Terminal sampler: one sample stage plus previous sample for edge detection
`timescale 1ns/1ps
`default_nettype none
module term_edge #(
  parameter int W = 17
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] cur_r;   // Current sample
  logic [W-1:0] prev_r;  // Sample one enabled cycle earlier

  // Sample the polarity-corrected terminals every enabled cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_r  <= '0;
      prev_r <= '0;
    end else if (ce) begin
      cur_r  <= raw;
      prev_r <= cur_r;
    end
  end

  // R24 edges from successive samples
  // Edges are one-cycle terms from two flops, so a held level fires once
  assign lvl  = cur_r;
  assign rise = cur_r & ~prev_r & {W{ce}};
  assign fall = ~cur_r & prev_r & {W{ce}};
endmodule
`default_nettype wire

// ---- testbench/ctrl_model.sv ----
// External controller and encoder stand-in that drives the input terminals
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input  wire logic        clk,
  output logic      [15:0] term_in,
  output logic             encoder_index,
  output logic      [31:0] actual_position
);
  // All terminals open, encoder parked at a fixed count
  initial begin
    term_in = 16'h0000;
    encoder_index = 1'b0;
    actual_position = 32'h0000beef;
  end

  // travel short
  // Homing travel stays a few cycles, far below the travel limit
  task automatic set(input int b, input logic v);
    @(posedge clk);
    term_in[b] <= v;
  endtask

  // One-cycle phase Z pulse from the encoder
  task automatic index_pulse();
    @(posedge clk);
    encoder_index <= 1'b1;
    @(posedge clk);
    encoder_index <= 1'b0;
  endtask

  // fault first
  // Fault input is released before the alarm reset pulse, never together
  task automatic reset_alarm();
    set(13, 1'b0);
    set(1, 1'b1);
    repeat (2) @(posedge clk);
    set(1, 1'b0);
  endtask

  // Encoder moves to a new count
  task automatic set_pos(input logic [31:0] p);
    @(posedge clk);
    actual_position <= p;
  endtask

  // hold, then reset
  // Alarm reset pulse only once encoder clear has been held past its hold time
  task automatic release_enc_clear();
    set(1, 1'b1);
    set(1, 1'b0);
    set(12, 1'b0);
  endtask
endmodule
`default_nettype wire

// ---- testbench/servo_input_command_logic_tb.sv ----
// Self-checking bench for the servo input command logic
`timescale 1ns/1ps
`default_nettype none
`include "servo_input_consts.svh"
module servo_input_command_logic_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        pos_mode = 1'b0;
  logic        inpos = 1'b0;
  logic        pulse = 1'b0;
  logic        prun = 1'b0;
  logic [31:0] rd;
  logic [15:0] term_in;
  logic        index, ack, pcomp, hmove, hrev, hfast, preset, mtclr, gain2, gear2, brk;
  logic [31:0] rdat, apos, pval, cmd_pos;
  logic [15:0] speed;
  logic [7:0]  err;
  int          n_errors = 0;
  int          n_compared = 0;
  int          n_pre = 0;
  int          n_mt = 0;
  int          cycles = 0;

  // 125 MHz clock
  always #4 clk = ~clk;

  ctrl_model P (.clk(clk), .term_in(term_in), .encoder_index(index), .actual_position(apos));

  // Short multi-turn hold keeps the run brief
  servo_input_command_logic #(.MT_HOLD_CYC(20)) DUT (
    .clk(clk), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .term_in(term_in),
    .encoder_index(index), .pos_mode(pos_mode), .in_position(inpos), .cmd_pulse(pulse),
    .cmd_dir(1'b0), .actual_position(apos), .prog_running(prun), .positioning_complete(pcomp),
    .homing_move(hmove), .homing_reverse(hrev), .homing_fast(hfast), .pos_preset(preset),
    .pos_preset_val(pval), .cmd_position(cmd_pos), .speed_cmd(speed), .gain_set2(gain2),
    .gear_set2(gear2), .enc_mt_clear(mtclr), .error_code(err), .dyn_brake(brk));

  // Pulse counters and the hang limit
  always @(posedge clk) begin
    cycles++;
    if (preset === 1'b1) n_pre++;
    if (mtclr === 1'b1) n_mt++;
    if (cycles == 4000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Let n edges pass, then look at settled outputs
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic md(input logic v);
    @(posedge clk);
    pos_mode <= v;
  endtask

  task automatic regs();
    wb(1'b0, `REG_CTRL, 0);
    chk("ctrl reset", `CTRL_RST, rd);
    wb(1'b0, 8'h40, 0);
    chk("unmapped", 0, rd);
    chk("power-up home", 0, pval);
  endtask

  task automatic homing();
    wb(1'b1, `REG_HOME_OFF_HI, 32'h0001);
    wb(1'b1, `REG_HOME_OFF_LO, 32'h2345);
    wb(1'b1, `REG_CTRL, {29'h0, `HM_SLOW_F});
    P.set(`T_SERVO_ON, 1'b1);
    P.set(`T_HOME_REQ, 1'b1);
    tk(4);
    chk("move off mode", 0, hmove);
    P.set(`T_HOME_REQ, 1'b0);
    md(1'b1);
    P.set(`T_HOME_REQ, 1'b1);
    tk(4);
    chk("move", 1, hmove);
    chk("reverse", 0, hrev);
    chk("slow", 0, hfast);
    chk("inp at start", 0, pcomp);
    P.set(`T_HOME_LIMIT, 1'b1);
    tk(4);
    chk("presets", 1, n_pre);
    chk("offset", 32'h00012345, pval);
    chk("inp done", 1, pcomp);
  endtask

  task automatic abort();
    P.set(`T_HOME_REQ, 1'b0);
    P.set(`T_HOME_LIMIT, 1'b0);
    wb(1'b1, `REG_CTRL, {29'h0, `HM_SLOW_R});
    P.set(`T_HOME_REQ, 1'b1);
    tk(4);
    chk("reverse", 1, hrev);
    P.set(`T_HOME_REQ, 1'b0);
    tk(3);
    chk("stopped", 0, hmove);
    chk("incomplete", 0, pcomp);
    // Limit alone must not home; only the index after it
    wb(1'b1, `REG_CTRL, {29'h0, `HM_FAST_IX_F});
    P.set(`T_HOME_REQ, 1'b1);
    P.set(`T_HOME_LIMIT, 1'b1);
    tk(4);
    chk("no index yet", 1, n_pre);
    chk("fast", 1, hfast);
    P.index_pulse();
    tk(4);
    chk("index home", 2, n_pre);
    P.set(`T_HOME_REQ, 1'b0);
  endtask

  task automatic clear_err();
    P.set(`T_ERR_CLEAR, 1'b1);
    tk(4);
    chk("cmd pos", 32'h0000beef, cmd_pos);
    P.set_pos(32'h00001234);
    tk(4);
    chk("held clear", 32'h0000beef, cmd_pos);
    // Three pulses while the gate is open, none once it is closed
    P.set(`T_PULSE_EN, 1'b1);
    @(posedge clk);
    pulse <= 1'b1;
    repeat (3) @(posedge clk);
    pulse <= 1'b0;
    tk(1);
    chk("pulse count", 32'h0000bef2, cmd_pos);
    P.set(`T_PULSE_EN, 1'b0);
    @(posedge clk);
    pulse <= 1'b1;
    repeat (2) @(posedge clk);
    pulse <= 1'b0;
    tk(1);
    chk("pulse gated", 32'h0000bef2, cmd_pos);
    P.set(`T_ERR_CLEAR, 1'b0);
  endtask

  task automatic speeds();
    wb(1'b1, `REG_SPEED1, 32'h0064);
    P.set(`T_FORWARD, 1'b1);
    P.set(`T_SPEED_SEL1, 1'b1);
    tk(3);
    chk("fwd speed", 16'h0064, speed);
    P.set(`T_REVERSE, 1'b1);
    tk(3);
    chk("both dirs", 0, speed);
    P.set(`T_FORWARD, 1'b0);
    tk(3);
    chk("rev speed", 16'hff9c, speed);
    P.set(`T_REVERSE, 1'b0);
  endtask

  task automatic gains();
    P.set(`T_GAIN_CHANGE, 1'b1);
    P.set(`T_GEAR_SEL, 1'b1);
    tk(3);
    chk("gain2", 1, gain2);
    chk("gear2", 1, gear2);
    md(1'b0);
    tk(3);
    chk("gain2 mode off", 0, gain2);
    md(1'b1);
    P.set(`T_GAIN_CHANGE, 1'b0);
    // Inverted terminal counts as active while open
    wb(1'b1, `REG_POLARITY, 32'h0400);
    tk(3);
    chk("gain2 inverted", 1, gain2);
    wb(1'b1, `REG_POLARITY, 0);
  endtask

  task automatic faults();
    wb(1'b1, `REG_CTRL, 32'h8);
    P.set(`T_EXT_FAULT, 1'b1);
    tk(3);
    chk("fault code", `ERR_EXT_FAULT, err);
    chk("brake", 1, brk);
    P.reset_alarm();
    tk(3);
    chk("fault clear", `ERR_NONE, err);
    P.set(`T_ENC_CLEAR, 1'b1);
    tk(10);
    chk("early mt clear", 0, n_mt);
    tk(20);
    chk("one mt clear", 1, n_mt);
    P.release_enc_clear();
  endtask

  // Probe edge captures only while the program source runs
  task automatic probes();
    wb(1'b1, `REG_CTRL, 32'h10);
    prun <= 1'b1;
    P.set(`T_PROBE_A, 1'b1);
    tk(3);
    wb(1'b0, `REG_PROBE_A_LO, 0);
    chk("probe a", 32'h1234, rd);
    prun <= 1'b0;
    P.set_pos(32'h00005678);
    P.set(`T_PROBE_A, 1'b0);
    tk(3);
    wb(1'b0, `REG_PROBE_A_LO, 0);
    chk("probe stopped", 32'h1234, rd);
  endtask

  // Reset for five cycles, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    regs();
    homing();
    abort();
    clear_err();
    speeds();
    gains();
    faults();
    probes();
    summarize();
  end
endmodule
`default_nettype wire
